// >>> hdl/afe_setup_cfg.svh
// Offsets, field positions, reset values and block power-enable bit indices of the set-up registers
`ifndef AFE_SETUP_CFG_SVH
`define AFE_SETUP_CFG_SVH
`define ADDR_POWER_SDO_MODE 6'h01
`define ADDR_BLOCK_POWER 6'h02
`define ADDR_SAMPLE_TIMING 6'h03
`define RST_POWER_SDO_MODE 8'h80
`define RST_BLOCK_POWER 8'h00
`define RST_SAMPLE_TIMING 8'h06
`define POS_POWER_EN 0
`define POS_SEL_EN 1
`define POS_SDO_LO 2
`define POS_SDO_HI 3
`define POS_MODE_LO 4
`define POS_MODE_HI 7
`define POS_RESREF_LO 0
`define POS_RESREF_HI 3
`define POS_FREE_RUN 4
`define POS_NARROW 5
`define POS_CHAN_LO 6
`define POS_CHAN_HI 7
`define BLK_BIAS 0
`define BLK_TOPBOT_REF 1
`define BLK_MID_REF 2
`define BLK_CLAMP_DAC 3
`define BLK_RED_SH 4
`define BLK_GREEN_SH 5
`define BLK_BLUE_SH 6
`define BLK_ADC 7
`endif

// >>> hdl/afe_setup_pkg.sv
// Types shared by the set-up register block
package afe_setup_pkg;
   typedef enum logic [1:0] {
      SDO_READBACK,
      SDO_TIMING_VIOLATION_FLAG,
      SDO_RANGE,
      SDO_SYNC
   } sdo_sel_t;
   typedef struct packed {
      logic [3:0] phases;
      logic cds;
      logic valid;
      logic [3:0] resref_max;
   } mode_info_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA
   } ser_state_t;
endpackage : afe_setup_pkg

// >>> hdl/afe_phase_gen.sv
// Sample phase counter and video/reset sample pulse generator
`timescale 1ns/100ps
`include "afe_setup_cfg.svh"
module afe_phase_gen
   import afe_setup_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Configuration
   input wire logic [3:0] phases_i,
   input wire logic cds_i,
   input wire logic [3:0] resref_i,
   input wire logic free_run_i,
   input wire logic narrow_i,
   input wire logic sync_rise_i,
   // Sample strobes
   output logic video_sample_o,
   output logic reset_sample_o,
   output logic ref_sample_o,
   output logic clamp_o,
   output logic narrow_o,
   output logic sync_out_o
);
   typedef struct packed {
      logic [3:0] phase;
      logic vs;
      logic rs;
      logic ref_s;
      logic cl;
      logic nar;
      logic sync;
   } pg_state_t;
   pg_state_t q, d;
   logic [3:0] nxt;
   always_comb begin
      d = q;
      nxt = q.phase + 4'h1;
      if (sync_rise_i && !free_run_i) begin
         nxt = 4'h0;
      end else if (q.phase >= phases_i - 4'h1) begin
         nxt = 4'h0;
      end
      d.phase = nxt;
      d.sync = (nxt == 4'h0);
      d.vs = (nxt == 4'h0);
      d.rs = cds_i && (nxt == resref_i);
      d.cl = (nxt == resref_i);
      d.ref_s = !cds_i && (nxt == 4'h0);
      d.nar = narrow_i;
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign video_sample_o = q.vs;
   assign reset_sample_o = q.rs;
   assign ref_sample_o = q.ref_s;
   assign clamp_o = q.cl;
   assign narrow_o = q.nar;
   assign sync_out_o = q.sync;
endmodule : afe_phase_gen

// >>> hdl/afe_setup_control_regs.sv
// Set-up registers 1 to 3 with serial control port, power enables and serial output mux
`timescale 1ns/100ps
`include "afe_setup_cfg.svh"
module afe_setup_control_regs
   import afe_setup_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Serial control port
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic sen_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Sample timing
   input wire logic sample_sync_i,
   input wire logic out_of_range_i,
   // Power enables, one per internal block
   output logic [7:0] block_power_o,
   // Sampling configuration
   output logic [3:0] mode_o,
   output logic [3:0] reset_ref_position_o,
   output logic [1:0] channel_o,
   output logic video_sample_o,
   output logic reset_sample_o,
   output logic ref_sample_o,
   output logic clamp_o,
   output logic narrow_o,
   output logic timing_violation_o
);
   typedef struct packed {
      logic [2:0] sclk_sy;
      logic [1:0] sdi_sy;
      logic [1:0] sen_sy;
      logic [1:0] sync_sy;
      logic [1:0] oor_sy;
      logic sync_prev;
      ser_state_t st;
      logic [3:0] cnt;
      logic rd;
      logic [5:0] addr;
      logic [7:0] shreg;
      logic [7:0] setup1;
      logic [7:0] setup2;
      logic [7:0] setup3;
      logic [7:0] power;
      logic sdo;
      logic sdo_oe;
      logic timing_violation_flag;
   } top_state_t;
   top_state_t q, d;
   mode_info_t mi;
   logic sclk_rise;
   logic sclk_fall;
   logic sync_rise;
   logic pg_sync;
   sdo_sel_t sel;

   function automatic mode_info_t decode_mode(input logic [3:0] m);
      mode_info_t r;
      r.cds = ~m[0];
      r.valid = 1'b1;
      case (m[3:1])
         3'h0: r.phases = 4'h8;
         3'h1: r.phases = 4'h1;
         3'h2: r.phases = 4'h6;
         3'h4: r.phases = 4'hc;
         3'h6: r.phases = 4'h8;
         default: begin
            r.phases = 4'hc;
            r.valid = 1'b0;
         end
      endcase
      r.resref_max = r.phases - 4'h1;
      return r;
   endfunction : decode_mode

   function automatic logic [7:0] read_reg(input logic [5:0] a, input top_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (a == `ADDR_POWER_SDO_MODE) begin
         v = s.setup1;
      end else if (a == `ADDR_BLOCK_POWER) begin
         v = s.setup2;
      end else if (a == `ADDR_SAMPLE_TIMING) begin
         v = s.setup3;
      end
      return v;
   endfunction : read_reg

   always_comb begin
      mi = decode_mode(q.setup1[`POS_MODE_HI:`POS_MODE_LO]);
      sel = sdo_sel_t'(q.setup1[`POS_SDO_HI:`POS_SDO_LO]);
   end
   assign sclk_rise = q.sclk_sy[1] && !q.sclk_sy[2];
   assign sclk_fall = !q.sclk_sy[1] && q.sclk_sy[2];
   // one rising edge per sync pulse
   assign sync_rise = q.sync_sy[1] && !q.sync_prev;

   always_comb begin
      d = q;
      d.sclk_sy = {q.sclk_sy[1:0], sclk_i};
      d.sdi_sy = {q.sdi_sy[0], sdi_i};
      d.sen_sy = {q.sen_sy[0], sen_i};
      d.sync_sy = {q.sync_sy[0], sample_sync_i};
      d.oor_sy = {q.oor_sy[0], out_of_range_i};
      d.sync_prev = q.sync_sy[1];
      // Frame: read bit, six address bits, eight data bits
      case (q.st)
         ST_IDLE: begin
            d.cnt = 4'h0;
            if (!q.sen_sy[1]) begin
               d.st = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (q.sen_sy[1]) begin
               d.st = ST_IDLE;
            end else if (sclk_rise) begin
               if (q.cnt == 4'h0) begin
                  d.rd = q.sdi_sy[1];
               end else begin
                  d.addr = {q.addr[4:0], q.sdi_sy[1]};
               end
               d.cnt = q.cnt + 4'h1;
               if (q.cnt == 4'h6) begin
                  d.st = ST_DATA;
                  d.cnt = 4'h0;
                  d.shreg = read_reg({q.addr[4:0], q.sdi_sy[1]}, q);
               end
            end
         end
         ST_DATA: begin
            if (q.sen_sy[1]) begin
               d.st = ST_IDLE;
               if (!q.rd && q.cnt == 4'h8) begin
                  if (q.addr == `ADDR_POWER_SDO_MODE) begin
                     d.setup1 = q.shreg;
                  end else if (q.addr == `ADDR_BLOCK_POWER) begin
                     d.setup2 = q.shreg;
                  end else if (q.addr == `ADDR_SAMPLE_TIMING) begin
                     d.setup3 = q.shreg;
                  end
               end
            end else if (sclk_rise && q.cnt != 4'h8) begin
               d.cnt = q.cnt + 4'h1;
               if (!q.rd) begin
                  d.shreg = {q.shreg[6:0], q.sdi_sy[1]};
               end
            end else if (sclk_fall && q.rd && q.cnt != 4'h0) begin
               d.shreg = {q.shreg[6:0], 1'b0};
            end
         end
         default: d.st = ST_IDLE;
      endcase
      if (q.setup1[`POS_SEL_EN]) begin
         d.power = q.setup2;
      end else begin
         d.power = {8{q.setup1[`POS_POWER_EN]}};
      end
      d.timing_violation_flag = !mi.valid || (q.setup3[`POS_RESREF_HI:`POS_RESREF_LO] > mi.resref_max);
      case (sel)
         SDO_READBACK: begin
            d.sdo_oe = (q.st == ST_DATA) && q.rd;
            d.sdo = q.shreg[7];
         end
         SDO_TIMING_VIOLATION_FLAG: begin
            d.sdo_oe = 1'b1;
            d.sdo = q.timing_violation_flag;
         end
         SDO_RANGE: begin
            d.sdo_oe = 1'b1;
            d.sdo = q.oor_sy[1];
         end
         default: begin
            d.sdo_oe = 1'b1;
            d.sdo = pg_sync;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
         q.sclk_sy <= 3'h0;
         q.sen_sy <= 2'h3;
         q.st <= ST_IDLE;
         q.setup1 <= `RST_POWER_SDO_MODE;
         q.setup2 <= `RST_BLOCK_POWER;
         q.setup3 <= `RST_SAMPLE_TIMING;
      end else begin
         q <= d;
      end
   end

   afe_phase_gen u_phase (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .phases_i(mi.phases),
      .cds_i(mi.cds),
      .resref_i(q.setup3[`POS_RESREF_HI:`POS_RESREF_LO]),
      .free_run_i(q.setup3[`POS_FREE_RUN]),
      .narrow_i(q.setup3[`POS_NARROW]),
      .sync_rise_i(sync_rise),
      .video_sample_o(video_sample_o),
      .reset_sample_o(reset_sample_o),
      .ref_sample_o(ref_sample_o),
      .clamp_o(clamp_o),
      .narrow_o(narrow_o),
      .sync_out_o(pg_sync)
   );

   assign sdo_o = q.sdo;
   assign sdo_oe_o = q.sdo_oe;
   assign block_power_o = q.power;
   assign mode_o = q.setup1[`POS_MODE_HI:`POS_MODE_LO];
   assign reset_ref_position_o = q.setup3[`POS_RESREF_HI:`POS_RESREF_LO];
   assign channel_o = q.setup3[`POS_CHAN_HI:`POS_CHAN_LO];
   assign timing_violation_o = q.timing_violation_flag;
endmodule : afe_setup_control_regs

// >>> verification/setup_properties.sv
// Checker for the set-up register block ports
`timescale 1ns/100ps
module setup_checker (
   // Clock, reset and host inputs
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sen_i,
   input wire logic sample_sync_i,
   // Design outputs
   input wire logic [7:0] block_power_o,
   input wire logic [3:0] mode_o,
   input wire logic [3:0] reset_ref_position_o,
   input wire logic video_sample_o,
   input wire logic reset_sample_o,
   input wire logic ref_sample_o,
   input wire logic clamp_o,
   input wire logic narrow_o,
   input wire logic timing_violation_o
);
   // Cycles since the last sync rise, to tell a restarted phase count from a short period
   logic sync_last_q;
   logic [3:0] sync_age_q;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_last_q <= 1'b0;
         sync_age_q <= 4'hf;
      end else begin
         sync_last_q <= sample_sync_i;
         if (sample_sync_i && !sync_last_q) begin
            sync_age_q <= 4'h0;
         end else if (sync_age_q != 4'hf) begin
            sync_age_q <= sync_age_q + 4'h1;
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   reset_vals_a: assert property ($rose(resetn_i) |->
      block_power_o == 8'h00 && mode_o == 4'h8 && reset_ref_position_o == 4'h6 && !narrow_o)
      else $error("wrong value after reset");
   mode_hold_a: assert property ($changed(mode_o) |-> $past(sen_i) && sen_i)
      else $error("mode changed inside a frame");
   power_hold_a: assert property ($changed(block_power_o) |-> $past(sen_i, 2) && sen_i)
      else $error("power enables changed inside a frame");
   nocds_ref_a: assert property (mode_o[0] && $stable(mode_o) |-> ref_sample_o == video_sample_o)
      else $error("reference sample apart from video sample");
   reset_clamp_a: assert property (reset_sample_o |-> clamp_o && !$past(mode_o[0]))
      else $error("reset sample without clamp or outside CDS");
   period_gap_a: assert property (video_sample_o && mode_o == 4'h8 |=>
      (!video_sample_o || mode_o != 4'h8 || sync_age_q == 4'h2)[*8])
      else $error("video samples too close in twelve phase mode");
   sync_video_a: assert property ($rose(sample_sync_i) |-> ##[1:5] video_sample_o)
      else $error("no video sample after sync");
   timing_violation_flag_set_a: assert property ((mode_o == 4'h8 && reset_ref_position_o > 4'hb)[*3] |->
      timing_violation_o)
      else $error("violation flag missing");
   timing_violation_flag_clear_a: assert property ((mode_o == 4'h8 && reset_ref_position_o < 4'hc)[*3] |->
      !timing_violation_o)
      else $error("violation flag false");
   cover property (timing_violation_o);
   cover property (ref_sample_o);
   cover property ($rose(narrow_o));
endmodule : setup_checker

bind afe_setup_control_regs setup_checker chk (.clk_i(clk_i), .resetn_i(resetn_i), .sen_i(sen_i),
   .sample_sync_i(sample_sync_i), .block_power_o(block_power_o), .mode_o(mode_o),
   .reset_ref_position_o(reset_ref_position_o), .video_sample_o(video_sample_o),
   .reset_sample_o(reset_sample_o), .ref_sample_o(ref_sample_o), .clamp_o(clamp_o),
   .narrow_o(narrow_o), .timing_violation_o(timing_violation_o));

// >>> verification/host_model.sv
// Host controller model for serial control frames
`timescale 1ns/100ps
module host_model (
   // Clock
   input wire logic clk_i,
   // Serial control port
   output logic sclk_o,
   output logic sdi_o,
   output logic sen_o,
   input wire logic sdo_i
);
   initial begin
      sclk_o = 1'b0;
      sdi_o = 1'b1;
      sen_o = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hold
   // Slow serial clock so the two-stage synchroniser sees every level
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [14:0] f;
      f = {rd, a, d};
      q = 8'h00;
      @(posedge clk_i);
      sen_o <= 1'b0;
      for (int i = 14; i >= 0; i--) begin
         hold(4);
         sdi_o <= f[i];
         hold(4);
         if (i < 8) q = {q[6:0], sdo_i};
         sclk_o <= 1'b1;
         hold(4);
         sclk_o <= 1'b0;
      end
      hold(4);
      sen_o <= 1'b1;
      // Deselected data line does not keep its last value
      sdi_o <= ~sdi_o;
      hold(6);
   endtask : xfer
endmodule : host_model

// >>> verification/testbench.sv
// Self-checking bench for the set-up register block
`timescale 1ns/100ps
module testbench;
   import afe_setup_pkg::*;
   typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] r; logic [7:0] p;} row_t;
   logic clk_i, resetn_i, sclk, sdi, sen, sdo, sdo_oe, sync, oor, narrow, timing_violation_flag;
   logic [7:0] power, q;
   logic [3:0] mode, rref;
   logic vs, rs, fs, cl;
   int n_mismatch, n_tests, nv, nr, nf, nc, ns;
   row_t rows[8] = '{'{6'h02, 8'h5a, 8'h5a, 8'h00}, '{6'h01, 8'h81, 8'h81, 8'hff},
      '{6'h01, 8'h82, 8'h82, 8'h5a}, '{6'h01, 8'h83, 8'h83, 8'h5a}, '{6'h02, 8'h81, 8'h81, 8'h81},
      '{6'h01, 8'h80, 8'h80, 8'h00}, '{6'h04, 8'hff, 8'h00, 8'h00}, '{6'h03, 8'h05, 8'h05, 8'h00}};
   logic [7:0] rst_v[3] = '{8'h80, 8'h00, 8'h06};
   afe_setup_control_regs uut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .sdi_i(sdi),
      .sen_i(sen), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sample_sync_i(sync), .out_of_range_i(oor),
      .block_power_o(power), .mode_o(mode), .reset_ref_position_o(rref), .channel_o(),
      .video_sample_o(vs), .reset_sample_o(rs), .ref_sample_o(fs), .clamp_o(cl), .narrow_o(narrow),
      .timing_violation_o(timing_violation_flag));
   host_model host (.clk_i(clk_i), .sclk_o(sclk), .sdi_o(sdi), .sen_o(sen), .sdo_i(sdo_oe ? sdo : 1'bz));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      #1;
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d, q);
   endtask : wr
   // Count strobes over n cycles, sync every per cycles when per is not zero
   task automatic run(input int n, input int per);
      nv = 0;
      nr = 0;
      nf = 0;
      nc = 0;
      ns = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         sync <= per != 0 && i % per == 0;
         #1;
         nv += vs === 1'b1;
         nr += rs === 1'b1;
         nf += fs === 1'b1;
         nc += cl === 1'b1;
         ns += sdo === 1'b1;
      end
   endtask : run
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      resetn_i = 1'b0;
      sync = 1'b0;
      oor = 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      host.hold(4);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         host.xfer(1'b1, rows[i].a, 8'h00, q);
         chk("readback", rows[i].r, q);
         chk("power", rows[i].p, power);
      end
      $display("test table done");
      chk("sdo enable", 8'h00, {7'h00, sdo_oe});
      run(24, 12);
      run(120, 12);
      chk("video count", 8'd10, 8'(nv));
      chk("reset count", 8'd10, 8'(nr));
      wr(6'h01, 8'h90);
      run(24, 12);
      run(120, 12);
      chk("ref count", 8'd10, 8'(nf));
      chk("reset count", 8'd0, 8'(nr));
      chk("clamp count", 8'd10, 8'(nc));
      wr(6'h03, 8'h16);
      run(24, 0);
      run(120, 0);
      chk("free count", 8'd10, 8'(nv));
      wr(6'h03, 8'h36);
      chk("narrow", 8'h01, {7'h00, narrow});
      $display("test sampling done");
      wr(6'h03, 8'h0f);
      wr(6'h01, 8'h84);
      chk("violation", 8'h01, {7'h00, timing_violation_flag});
      chk("sdo flag", 8'h01, {7'h00, sdo});
      @(posedge clk_i);
      oor <= 1'b1;
      wr(6'h01, 8'h88);
      chk("sdo range", 8'h01, {7'h00, sdo});
      @(posedge clk_i);
      oor <= 1'b0;
      host.hold(6);
      chk("sdo range", 8'h00, {7'h00, sdo});
      wr(6'h01, 8'h8c);
      run(24, 12);
      run(120, 12);
      chk("sdo sync", 8'd10, 8'(ns));
      wr(6'h03, 8'h06);
      wr(6'h01, 8'h44);
      chk("violation", 8'h01, {7'h00, timing_violation_flag});
      wr(6'h01, 8'hc4);
      chk("violation", 8'h00, {7'h00, timing_violation_flag});
      run(24, 8);
      run(120, 8);
      chk("video count", 8'd15, 8'(nv));
      chk("reset count", 8'd15, 8'(nr));
      $display("test output select done");
      @(posedge clk_i);
      resetn_i <= 1'b0;
      host.hold(2);
      resetn_i <= 1'b1;
      host.hold(4);
      for (int i = 0; i < 3; i++) begin
         host.xfer(1'b1, 6'(i + 1), 8'h00, q);
         chk("reset value", rst_v[i], q);
      end
      chk("power", 8'h00, power);
      $display("test reset done");
      test_done();
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      n_mismatch++;
      test_done();
   end
endmodule : testbench
